// *** include/pdm_pkg.sv ***
package pdm_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [7:0] CPU_CONTROL_STATUS_ADDR = 8'h00;
	localparam logic [7:0] PDM_STATUS_ADDR = 8'h04;
	localparam logic [7:0] PDM_LOCK_CFG_ADDR = 8'h08;

	// Power-down field position and width
	localparam int SEL_LSB = 10;
	localparam int SEL_MSB = 15;
	localparam int SEL_W = 6;

	// Other control/status bits held here
	localparam int GLOBAL_IRQ_EN_BIT = 0;
	localparam int NMI_EN_BIT = 1;

	// Field codes
	localparam logic [5:0] CODE_NONE = 6'h00;
	localparam logic [5:0] CODE_LIGHT_ENABLED = 6'h09;
	localparam logic [5:0] CODE_LIGHT_ANY = 6'h11;
	localparam logic [5:0] CODE_DEEP_HALT = 6'h1a;
	localparam logic [5:0] CODE_OSC_STOP = 6'h1c;

	// Reset values
	localparam logic [31:0] CPU_CONTROL_STATUS_RESET = 32'h0000_0000;

	// Timing
	localparam int CLK_MHZ = 250;
	localparam int ENTRY_DELAY_CYCLES = 9;
	localparam int PLL_LOCK_TYPICAL_US = 75;
	localparam int PLL_LOCK_MARGIN_PCT = 150;
	localparam int PLL_LOCK_CYCLES = PLL_LOCK_TYPICAL_US * CLK_MHZ * (100 + PLL_LOCK_MARGIN_PCT) / 100;

	// Controller states
	typedef enum logic [5:0] {
		ST_RUN = 6'b000001,
		ST_ARMED = 6'b000010,
		ST_LIGHT = 6'b000100,
		ST_DEEP = 6'b001000,
		ST_OSC = 6'b010000,
		ST_RELOCK = 6'b100000
	} pdm_state_type;

	typedef enum logic [1:0] {
		MODE_NONE = 2'b00,
		MODE_LIGHT = 2'b01,
		MODE_DEEP = 2'b10,
		MODE_OSC = 2'b11
	} pdm_mode_type;

endpackage

// *** rtl/pdm_sync.sv ***
module pdm_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Data
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stage1 <= '0;
			stage2 <= '0;
		end else begin
			stage1 <= i_async;
			stage2 <= stage1;
		end
	end

	assign o_sync = stage2;

endmodule

// *** rtl/pdm_lock_timer.sv ***
module pdm_lock_timer #(
	parameter int COUNT = 46875
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Control
	input wire logic i_start,
	input wire logic i_pll_locked,
	output logic o_done
);

	localparam int CW = $clog2(COUNT + 1);

	if (COUNT < 1) begin
		$error("pdm_lock_timer: COUNT must be at least 1");
	end

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic busy;
	logic next_busy;

	always_comb begin
		next_count = count;
		next_busy = busy;
		if (i_start) begin
			next_count = CW'(COUNT);
			next_busy = 1'b1;
		end else if (busy) begin
			// Lock indication cuts the wait short; counter is the worst-case bound
			if (i_pll_locked || count == CW'(1)) begin
				next_busy = 1'b0;
				next_count = '0;
			end else begin
				next_count = count - CW'(1);
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count <= '0;
			busy <= 1'b0;
		end else begin
			count <= next_count;
			busy <= next_busy;
		end
	end

	assign o_done = busy && !next_busy;

endmodule

// *** rtl/pdm_top.sv ***
// The implementer's own choices: the register offsets and the address-and-strobe port.
module pdm_top #(
	parameter int LOCK_CYCLES = pdm_pkg::PLL_LOCK_CYCLES,
	parameter int ENTRY_DELAY = pdm_pkg::ENTRY_DELAY_CYCLES
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Register port
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	// Interrupt inputs from the interrupt logic
	input wire logic i_irq_pending,
	input wire logic i_irq_enabled,
	// PLL
	input wire logic i_pll_locked,
	// Clock gating controls
	output logic o_cpu_clk_en,
	output logic o_pll_out_en,
	output logic o_ref_clk_en,
	output logic o_dma_clk_en,
	output logic o_io_freeze,
	// CPU wake control
	output logic o_cpu_wake,
	output logic o_cpu_service_irq,
	output logic [1:0] o_mode
);

	if (ENTRY_DELAY < 1 || ENTRY_DELAY > 15) begin
		$error("pdm_top: ENTRY_DELAY out of range");
	end
	if (LOCK_CYCLES < 1) begin
		$error("pdm_top: LOCK_CYCLES must be positive");
	end

	////////////////////////////////////////////////////////////////////////
	// Reset release and input synchronisation

	logic rst_meta;
	logic rst_n;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	logic [2:0] sync_in;

	pdm_sync #(
		.WIDTH(3)
	) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(rst_n),
		.i_async({i_irq_pending, i_irq_enabled, i_pll_locked}),
		.o_sync(sync_in)
	);

	logic irq_pending;
	logic irq_enabled;
	logic pll_locked;

	assign irq_pending = sync_in[2];
	assign irq_enabled = sync_in[1];
	assign pll_locked = sync_in[0];

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Unknown codes fall back to running
	function automatic pdm_pkg::pdm_mode_type decode_mode(input logic [5:0] code);
		if (code == pdm_pkg::CODE_LIGHT_ENABLED || code == pdm_pkg::CODE_LIGHT_ANY) begin
			decode_mode = pdm_pkg::MODE_LIGHT;
		end else if (code == pdm_pkg::CODE_DEEP_HALT) begin
			decode_mode = pdm_pkg::MODE_DEEP;
		end else if (code == pdm_pkg::CODE_OSC_STOP) begin
			decode_mode = pdm_pkg::MODE_OSC;
		end else begin
			decode_mode = pdm_pkg::MODE_NONE;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register file

	logic [5:0] power_down_select_field;
	logic [5:0] next_power_down_select_field;
	logic global_interrupt_enable;
	logic next_global_interrupt_enable;
	logic nonmaskable_interrupt_enable;
	logic next_nonmaskable_interrupt_enable;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic osc_wake_pending;
	logic next_osc_wake_pending;

	pdm_pkg::pdm_state_type state;
	pdm_pkg::pdm_state_type next_state;

	logic csr_wr;
	logic wake;

	always_comb begin
		csr_wr = i_reg_wr && i_reg_addr == pdm_pkg::CPU_CONTROL_STATUS_ADDR;
		next_power_down_select_field = power_down_select_field;
		next_global_interrupt_enable = global_interrupt_enable;
		next_nonmaskable_interrupt_enable = nonmaskable_interrupt_enable;
		next_rdata = 32'h0000_0000;
		if (csr_wr) begin
			// Whole field taken at once; a split update passes a partial code
			next_power_down_select_field = i_reg_wdata[pdm_pkg::SEL_MSB:pdm_pkg::SEL_LSB];
			next_global_interrupt_enable = i_reg_wdata[pdm_pkg::GLOBAL_IRQ_EN_BIT];
			next_nonmaskable_interrupt_enable = i_reg_wdata[pdm_pkg::NMI_EN_BIT];
		end else if (wake) begin
			// Field clears on wake so the CPU does not re-enter
			next_power_down_select_field = pdm_pkg::CODE_NONE;
		end
		if (i_reg_rd) begin
			if (i_reg_addr == pdm_pkg::CPU_CONTROL_STATUS_ADDR) begin
				next_rdata[pdm_pkg::SEL_MSB:pdm_pkg::SEL_LSB] = power_down_select_field;
				next_rdata[pdm_pkg::GLOBAL_IRQ_EN_BIT] = global_interrupt_enable;
				next_rdata[pdm_pkg::NMI_EN_BIT] = nonmaskable_interrupt_enable;
			end else if (i_reg_addr == pdm_pkg::PDM_STATUS_ADDR) begin
				next_rdata[5:0] = state;
				next_rdata[8] = osc_wake_pending;
				next_rdata[9] = pll_locked;
			end else if (i_reg_addr == pdm_pkg::PDM_LOCK_CFG_ADDR) begin
				next_rdata = 32'(LOCK_CYCLES);
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			power_down_select_field <= pdm_pkg::CPU_CONTROL_STATUS_RESET[pdm_pkg::SEL_MSB:pdm_pkg::SEL_LSB];
			global_interrupt_enable <= 1'b0;
			nonmaskable_interrupt_enable <= 1'b0;
			rdata <= 32'h0000_0000;
		end else begin
			power_down_select_field <= next_power_down_select_field;
			global_interrupt_enable <= next_global_interrupt_enable;
			nonmaskable_interrupt_enable <= next_nonmaskable_interrupt_enable;
			rdata <= next_rdata;
		end
	end

	assign o_reg_rdata = rdata;

	////////////////////////////////////////////////////////////////////////
	// Entry delay, mode state machine

	logic [3:0] delay;
	logic [3:0] next_delay;
	logic [5:0] armed_code;
	logic [5:0] next_armed_code;
	logic service;
	logic next_service;
	logic wake_q;
	logic lock_start;
	logic lock_done;

	always_comb begin
		next_state = state;
		next_delay = delay;
		next_armed_code = armed_code;
		next_service = 1'b0;
		next_osc_wake_pending = osc_wake_pending;
		wake = 1'b0;
		lock_start = 1'b0;
		case (state)
			pdm_pkg::ST_RUN: begin
				if (csr_wr && decode_mode(i_reg_wdata[pdm_pkg::SEL_MSB:pdm_pkg::SEL_LSB]) != pdm_pkg::MODE_NONE) begin
					next_state = pdm_pkg::ST_ARMED;
					next_armed_code = i_reg_wdata[pdm_pkg::SEL_MSB:pdm_pkg::SEL_LSB];
					next_delay = 4'(ENTRY_DELAY - 1);
				end
			end
			pdm_pkg::ST_ARMED: begin
				// Fixed worst-case latency so software padding always covers it
				if (delay == 4'h0) begin
					case (decode_mode(armed_code))
						pdm_pkg::MODE_LIGHT: next_state = pdm_pkg::ST_LIGHT;
						pdm_pkg::MODE_DEEP: next_state = pdm_pkg::ST_DEEP;
						pdm_pkg::MODE_OSC: next_state = pdm_pkg::ST_OSC;
						default: next_state = pdm_pkg::ST_RUN;
					endcase
				end else begin
					next_delay = delay - 4'h1;
				end
			end
			pdm_pkg::ST_LIGHT: begin
				if (irq_pending && (irq_enabled || armed_code == pdm_pkg::CODE_LIGHT_ANY)) begin
					wake = 1'b1;
					next_state = pdm_pkg::ST_RUN;
					next_service = irq_enabled && global_interrupt_enable
						&& nonmaskable_interrupt_enable;
				end
			end
			pdm_pkg::ST_DEEP: begin
				next_state = pdm_pkg::ST_DEEP;
			end
			pdm_pkg::ST_OSC: begin
				next_state = pdm_pkg::ST_OSC;
			end
			pdm_pkg::ST_RELOCK: begin
				if (lock_done) begin
					next_state = pdm_pkg::ST_RUN;
					next_osc_wake_pending = 1'b0;
				end
			end
			default: next_state = pdm_pkg::ST_RUN;
		endcase
		if (state == pdm_pkg::ST_RELOCK && delay == 4'hf) begin
			lock_start = 1'b1;
			next_delay = 4'h0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			// Device reset is the only way out of the deep modes; power-up relocks too
			state <= pdm_pkg::ST_RELOCK;
			delay <= 4'hf;
			armed_code <= pdm_pkg::CODE_NONE;
			service <= 1'b0;
			osc_wake_pending <= 1'b1;
			wake_q <= 1'b0;
		end else begin
			state <= next_state;
			delay <= next_delay;
			armed_code <= next_armed_code;
			service <= next_service;
			osc_wake_pending <= next_osc_wake_pending;
			wake_q <= wake;
		end
	end

	pdm_lock_timer #(
		.COUNT(LOCK_CYCLES)
	) u_lock (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(rst_n),
		.i_start(lock_start),
		.i_pll_locked(pll_locked),
		.o_done(lock_done)
	);

	////////////////////////////////////////////////////////////////////////
	// Outputs; contents are held since only clocks are gated

	logic cpu_en;
	logic pll_en;
	logic ref_en;
	logic freeze;
	logic [1:0] mode_q;

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cpu_en <= 1'b0;
			pll_en <= 1'b1;
			ref_en <= 1'b1;
			freeze <= 1'b0;
			mode_q <= pdm_pkg::MODE_NONE;
		end else begin
			cpu_en <= next_state == pdm_pkg::ST_RUN || next_state == pdm_pkg::ST_ARMED;
			pll_en <= next_state != pdm_pkg::ST_DEEP && next_state != pdm_pkg::ST_OSC;
			ref_en <= next_state != pdm_pkg::ST_OSC;
			freeze <= next_state == pdm_pkg::ST_DEEP || next_state == pdm_pkg::ST_OSC;
			mode_q <= next_state == pdm_pkg::ST_LIGHT ? pdm_pkg::MODE_LIGHT :
				next_state == pdm_pkg::ST_DEEP ? pdm_pkg::MODE_DEEP :
				next_state == pdm_pkg::ST_OSC ? pdm_pkg::MODE_OSC : pdm_pkg::MODE_NONE;
		end
	end

	assign o_cpu_clk_en = cpu_en;
	assign o_pll_out_en = pll_en;
	assign o_ref_clk_en = ref_en;
	assign o_dma_clk_en = pll_en;
	assign o_io_freeze = freeze;
	assign o_cpu_wake = wake_q;
	assign o_cpu_service_irq = service;
	assign o_mode = mode_q;

endmodule

// *** bench/pdm_top_asserts.sv ***
module pdm_top_asserts (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Register port
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	// Power controls
	input wire logic o_cpu_clk_en,
	input wire logic o_pll_out_en,
	input wire logic o_ref_clk_en,
	input wire logic o_dma_clk_en,
	input wire logic o_io_freeze,
	input wire logic o_cpu_wake,
	input wire logic o_cpu_service_irq,
	input wire logic [1:0] o_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////
	logic [5:0] wcode;
	logic wr_idle;
	assign wcode = i_reg_wdata[15:10];
	// Only writes from full run count; a write during relock is never acted on
	assign wr_idle = i_reg_wr && i_reg_addr == pdm_pkg::CPU_CONTROL_STATUS_ADDR && o_mode == 2'h0 && o_cpu_clk_en;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////
	a_light_entry: assert property (wr_idle && (wcode == 6'h09 || wcode == 6'h11) |-> ##[1:10] o_mode == 2'h1)
		else $error("light mode late");
	a_deep_entry: assert property (wr_idle && wcode == 6'h1a |-> ##[1:10] o_mode == 2'h2)
		else $error("deep halt late");
	a_osc_entry: assert property (wr_idle && wcode == 6'h1c |-> ##[1:10] o_mode == 2'h3)
		else $error("oscillator stop late");
	a_reserved_none: assert property (wr_idle && !(wcode inside {6'h00, 6'h09, 6'h11, 6'h1a, 6'h1c})
		|=> (o_mode == 2'h0 && o_cpu_clk_en)[*8])
		else $error("reserved code acted on");
	a_light_gate: assert property (o_mode == 2'h1 |-> !o_cpu_clk_en && o_dma_clk_en && o_ref_clk_en)
		else $error("light gating wrong");
	a_deep_halt: assert property (o_mode == 2'h2 |-> !o_pll_out_en && o_ref_clk_en)
		else $error("deep halt clocks wrong");
	a_ref_gate: assert property (o_ref_clk_en == (o_mode != 2'h3))
		else $error("reference gate wrong");
	a_io_freeze: assert property (o_mode[1] |-> o_io_freeze && !o_cpu_clk_en)
		else $error("outputs not frozen");
	a_deep_sticky: assert property (o_mode[1] |=> $stable(o_mode))
		else $error("deep mode left without reset");
	a_service_pair: assert property (o_cpu_service_irq |-> o_cpu_wake)
		else $error("service without wake");
	a_wake_pulse: assert property (o_cpu_wake |-> o_cpu_clk_en && o_mode == 2'h0 ##1 !o_cpu_wake)
		else $error("wake pulse wrong");
	c_service: cover property (o_cpu_service_irq);
	c_plain_wake: cover property (o_cpu_wake && !o_cpu_service_irq);
	c_deep: cover property (o_mode == 2'h2);
	c_osc: cover property (o_mode == 2'h3);
endmodule

// *** bench/pdm_top_bench.sv ***
module pdm_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LOCK = 20;
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] i_reg_addr = 8'h00;
	logic [31:0] i_reg_wdata = 32'h0;
	logic i_reg_wr = 1'b0;
	logic i_reg_rd = 1'b0;
	logic i_irq_pending = 1'b0;
	logic i_irq_enabled = 1'b0;
	logic i_pll_locked = 1'b0;
	logic [31:0] o_reg_rdata;
	logic o_cpu_clk_en, o_pll_out_en, o_ref_clk_en, o_dma_clk_en, o_io_freeze, o_cpu_wake, o_cpu_service_irq;
	logic [1:0] o_mode;
	int n_errors = 0;
	int checked = 0;
	int cnt;
	logic [31:0] rd_val;
	logic [5:0] codes [3] = '{6'h09, 6'h09, 6'h11};
	logic [1:0] lowb [3] = '{2'h3, 2'h0, 2'h3};
	logic ens [3] = '{1'b1, 1'b1, 1'b0};
	logic svc [3] = '{1'b1, 1'b0, 1'b0};
	always #2 i_clk_sys = ~i_clk_sys;
	// Short lock count keeps the relock waits brief
	pdm_top #(.LOCK_CYCLES(LOCK)) i_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
		.i_irq_pending(i_irq_pending), .i_irq_enabled(i_irq_enabled), .i_pll_locked(i_pll_locked),
		.o_cpu_clk_en(o_cpu_clk_en), .o_pll_out_en(o_pll_out_en), .o_ref_clk_en(o_ref_clk_en),
		.o_dma_clk_en(o_dma_clk_en), .o_io_freeze(o_io_freeze), .o_cpu_wake(o_cpu_wake),
		.o_cpu_service_irq(o_cpu_service_irq), .o_mode(o_mode));
	////////////////////////////////////////
	task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		if (n_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_clk_sys);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_clk_sys);
		i_reg_rd <= 1'b0;
		#1;
		rd_val = o_reg_rdata;
	endtask
	// Bounded wait for the clock enable or the wake pulse
	task automatic wait_on(input bit wake, output int n);
		n = 0;
		do begin
			@(posedge i_clk_sys);
			#1;
			n++;
			if (n > 200) begin
				n_errors++;
				give_verdict();
			end
		end while ((wake ? o_cpu_wake : o_cpu_clk_en) !== 1'b1);
	endtask
	task automatic do_reset(input logic locked);
		@(posedge i_clk_sys);
		i_pll_locked <= locked;
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		wait_on(1'b0, cnt);
	endtask
	task automatic settle();
		repeat (10) @(posedge i_clk_sys);
		#1;
	endtask
	////////////////////////////////////////
	initial begin
		do_reset(1'b0);
		cmp({31'h0, cnt >= LOCK}, 32'h1);
		rd(8'h04);
		cmp(rd_val, 32'h0000_0001);
		rd(8'h08);
		cmp(rd_val, 32'(LOCK));
		wr(8'h00, 32'h0000_0403);
		settle();
		cmp({30'h0, o_mode}, 32'h0);
		rd(8'h00);
		cmp(rd_val & 32'h0000_fc03, 32'h0000_0403);
		rd(8'h40);
		cmp(rd_val, 32'h0);
		for (int k = 0; k < 3; k++) begin
			wr(8'h00, {16'h0, codes[k], 8'h00, lowb[k]});
			settle();
			cmp({30'h0, o_mode}, 32'h1);
			cmp({31'h0, o_cpu_clk_en}, 32'h0);
			cmp({31'h0, o_dma_clk_en}, 32'h1);
			if (k == 0) begin
				@(posedge i_clk_sys);
				i_irq_pending <= 1'b1;
				settle();
				cmp({30'h0, o_mode}, 32'h1);
			end
			@(posedge i_clk_sys);
			i_irq_pending <= 1'b1;
			i_irq_enabled <= ens[k];
			wait_on(1'b1, cnt);
			cmp({31'h0, o_cpu_service_irq}, {31'h0, svc[k]});
			@(posedge i_clk_sys);
			i_irq_pending <= 1'b0;
			i_irq_enabled <= 1'b0;
			rd(8'h00);
			cmp({26'h0, rd_val[15:10]}, 32'h0);
		end
		wr(8'h00, 32'h0000_6800);
		settle();
		cmp({30'h0, o_mode}, 32'h2);
		cmp({o_pll_out_en, o_ref_clk_en, o_io_freeze}, 32'h3);
		@(posedge i_clk_sys);
		i_irq_pending <= 1'b1;
		i_irq_enabled <= 1'b1;
		repeat (3) settle();
		cmp({30'h0, o_mode}, 32'h2);
		@(posedge i_clk_sys);
		i_irq_pending <= 1'b0;
		do_reset(1'b1);
		cmp({30'h0, o_mode}, 32'h0);
		rd(8'h04);
		cmp(rd_val, 32'h0000_0201);
		wr(8'h00, 32'h0000_7000);
		settle();
		cmp({30'h0, o_mode}, 32'h3);
		cmp({o_ref_clk_en, o_io_freeze}, 32'h1);
		do_reset(1'b0);
		cmp({31'h0, cnt >= LOCK}, 32'h1);
		give_verdict();
	end
endmodule

bind pdm_top pdm_top_asserts i_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .o_cpu_clk_en(o_cpu_clk_en), .o_pll_out_en(o_pll_out_en),
	.o_ref_clk_en(o_ref_clk_en), .o_dma_clk_en(o_dma_clk_en), .o_io_freeze(o_io_freeze),
	.o_cpu_wake(o_cpu_wake), .o_cpu_service_irq(o_cpu_service_irq), .o_mode(o_mode));
